// ==== src/tsr_core.sv ====
`timescale 1ns/1ns
module tsr_core #(
    parameter logic [19:0] UPDATE_CYC = 20'(tsr_pkg::UPDATE_CYC),
    parameter logic [19:0] CONV_CYC = 20'(tsr_pkg::CONV_CYC)
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Byte-level register port from the serial interface.
    input wire logic bus_start,
    input wire logic bus_rnw,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rd_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Converter front end.
    input wire logic [11:0] adc_code,
    output logic conv_active,
    // Open-drain overtemperature pin.
    output logic overtemp_output,
    output logic overtemp_oe
);

    logic [7:0] pointer_r;
    logic [7:0] cfg_r;
    logic [15:0] temp_r;
    logic [15:0] hyst_r;
    logic [15:0] os_r;
    logic [7:0] msb_hold_r;
    logic [1:0] byte_idx_r;
    logic first_wr_r;
    logic rnw_r;
    logic [15:0] rd_snap_r;
    tsr_pkg::tsr_seq_t seq_r;
    tsr_pkg::tsr_seq_t seq_nxt;
    logic [19:0] cnt_r;
    logic single_r;
    logic [2:0] fault_cnt_r;
    logic alert_r;
    logic read_seen_r;
    logic cold_seen_r;
    logic [15:0] sel_val;
    logic [2:0] fault_need;
    logic sleep_mode;
    logic conv_done;
    logic hot;
    logic cold;
    logic oneshot_wr;
    logic data_wr;

    // Shutdown or one-shot mode both keep the converter asleep.
    assign sleep_mode = cfg_r[tsr_pkg::CFG_SHUTDOWN_BIT] | cfg_r[tsr_pkg::CFG_ONESHOT_BIT];
    assign conv_done = (seq_r == tsr_pkg::SEQ_CONV) && (cnt_r == CONV_CYC - 20'h00001);
    assign conv_active = (seq_r == tsr_pkg::SEQ_CONV);

    // Signed compare of the fresh code against both limits.
    assign hot = $signed(adc_code) >= $signed(os_r[15:4]);
    assign cold = $signed(adc_code) < $signed(hyst_r[15:4]);

    // A data byte in a write transaction, after the pointer byte.
    assign data_wr = wr_valid && !rnw_r && !first_wr_r;
    assign oneshot_wr = data_wr && (pointer_r[2:0] == tsr_pkg::PTR_ONESHOT) && (byte_idx_r == 2'h0);

    // Fault queue depth decode.
    always_comb begin
        case (cfg_r[tsr_pkg::CFG_FQ_LSB +: 2])
            2'b00: fault_need = tsr_pkg::FQ_NEED_0;
            2'b01: fault_need = tsr_pkg::FQ_NEED_1;
            2'b10: fault_need = tsr_pkg::FQ_NEED_2;
            2'b11: fault_need = tsr_pkg::FQ_NEED_3;
            default: fault_need = tsr_pkg::FQ_NEED_0;
        endcase
    end

    // Read mux; the one-shot and unused codes read as zero.
    always_comb begin
        case (pointer_r[2:0])
            tsr_pkg::PTR_TEMP: sel_val = temp_r;
            tsr_pkg::PTR_CFG: sel_val = {cfg_r & tsr_pkg::CFG_WR_MASK, cfg_r & tsr_pkg::CFG_WR_MASK};
            tsr_pkg::PTR_HYST: sel_val = hyst_r;
            tsr_pkg::PTR_OS: sel_val = os_r;
            default: sel_val = 16'h0000;
        endcase
    end

    // Transaction tracking: direction, pointer phase and byte index.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rnw_r <= 1'b1;
            first_wr_r <= 1'b0;
            byte_idx_r <= 2'h0;
        end else if (bus_start) begin
            rnw_r <= bus_rnw;
            first_wr_r <= !bus_rnw;
            byte_idx_r <= 2'h0;
        end else if (wr_valid && !rnw_r) begin
            first_wr_r <= 1'b0;
            if (!first_wr_r && byte_idx_r != 2'h2) begin
                byte_idx_r <= byte_idx_r + 2'h1;
            end
        end else if (rd_req && rnw_r) begin
            byte_idx_r <= {1'b0, ~byte_idx_r[0]};
        end
    end

    // Pointer takes the first byte of each write transaction.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pointer_r <= tsr_pkg::PTR_RESET;
        end else if (wr_valid && !rnw_r && first_wr_r) begin
            pointer_r <= wr_data;
        end
    end

    // Configuration register; reserved bits are not stored.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= tsr_pkg::CFG_RESET;
        end else if (data_wr && byte_idx_r == 2'h0 && pointer_r[2:0] == tsr_pkg::PTR_CFG) begin
            cfg_r <= wr_data & tsr_pkg::CFG_WR_MASK;
        end
    end

    // Upper byte of a limit write waits here until the lower byte arrives.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            msb_hold_r <= 8'h00;
        end else if (data_wr && byte_idx_r == 2'h0) begin
            msb_hold_r <= wr_data;
        end
    end

    // Limit registers commit both bytes at once on the lower byte.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hyst_r <= tsr_pkg::HYST_RESET;
            os_r <= tsr_pkg::OS_RESET;
        end else if (data_wr && byte_idx_r == 2'h1) begin
            if (pointer_r[2:0] == tsr_pkg::PTR_HYST) begin
                hyst_r <= {msb_hold_r, wr_data[7:4], 4'h0};
            end
            if (pointer_r[2:0] == tsr_pkg::PTR_OS) begin
                os_r <= {msb_hold_r, wr_data[7:4], 4'h0};
            end
        end
    end

    // Read path: snapshot on the first byte so both bytes match.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_snap_r <= 16'h0000;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req && rnw_r;
            if (rd_req && rnw_r) begin
                if (byte_idx_r == 2'h0) begin
                    rd_snap_r <= sel_val;
                    rd_data <= sel_val[15:8];
                end else begin
                    rd_data <= rd_snap_r[7:0];
                end
            end
        end
    end

    // Sequencer next state.
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            tsr_pkg::SEQ_IDLE: begin
                if (!sleep_mode || oneshot_wr) begin
                    seq_nxt = tsr_pkg::SEQ_CONV;
                end
            end
            tsr_pkg::SEQ_CONV: begin
                if (sleep_mode && !single_r) begin
                    seq_nxt = tsr_pkg::SEQ_IDLE;
                end else if (conv_done) begin
                    seq_nxt = single_r ? tsr_pkg::SEQ_IDLE : tsr_pkg::SEQ_WAIT;
                end
            end
            tsr_pkg::SEQ_WAIT: begin
                if (sleep_mode) begin
                    seq_nxt = tsr_pkg::SEQ_IDLE;
                end else if (cnt_r == UPDATE_CYC - 20'h00001) begin
                    seq_nxt = tsr_pkg::SEQ_CONV;
                end
            end
            default: seq_nxt = tsr_pkg::SEQ_IDLE;
        endcase
    end

    // Sequencer state and the cycle counter that times it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            seq_r <= tsr_pkg::SEQ_IDLE;
            cnt_r <= 20'h00000;
            single_r <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
            if (seq_r != tsr_pkg::SEQ_CONV && seq_nxt == tsr_pkg::SEQ_CONV) begin
                cnt_r <= 20'h00000;
                single_r <= sleep_mode;
            end else if (seq_r != tsr_pkg::SEQ_IDLE) begin
                cnt_r <= cnt_r + 20'h00001;
            end
        end
    end

    // Result register updates whole at conversion end, never from the bus.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            temp_r <= tsr_pkg::TEMP_RESET;
        end else if (conv_done) begin
            temp_r <= {adc_code, 4'h0};
        end
    end

    // Consecutive fault counter, restarted by any non-fault result.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fault_cnt_r <= 3'h0;
        end else if (conv_done) begin
            if (!hot) begin
                fault_cnt_r <= 3'h0;
            end else if (fault_cnt_r < fault_need) begin
                fault_cnt_r <= fault_cnt_r + 3'h1;
            end
        end
    end

    // Alert state; a trip wins over any clear in the same cycle.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            alert_r <= 1'b0;
            read_seen_r <= 1'b0;
            cold_seen_r <= 1'b0;
        end else if (conv_done && hot && fault_cnt_r + 3'h1 >= fault_need) begin
            alert_r <= 1'b1;
            read_seen_r <= 1'b0;
            cold_seen_r <= 1'b0;
        end else if (alert_r) begin
            if (!cfg_r[tsr_pkg::CFG_INTMODE_BIT]) begin
                if (conv_done && cold) begin
                    alert_r <= 1'b0;
                end
            end else begin
                if ((read_seen_r || (rd_req && rnw_r)) && (cold_seen_r || (conv_done && cold))) begin
                    alert_r <= 1'b0;
                end
                if (rd_req && rnw_r) begin
                    read_seen_r <= 1'b1;
                end
                if (conv_done && cold) begin
                    cold_seen_r <= 1'b1;
                end
            end
        end
    end

    // Open drain: pulls low when the pin should show a low level.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            overtemp_oe <= 1'b0;
        end else begin
            overtemp_oe <= alert_r ^ cfg_r[tsr_pkg::CFG_POL_BIT];
        end
    end

    // The pin only ever drives low.
    assign overtemp_output = 1'b0;

endmodule // tsr_core

// ==== pkg/tsr_pkg.sv ====
package tsr_pkg;

    // Register select codes carried in the low bits of the pointer.
    localparam logic [2:0] PTR_TEMP = 3'h0;
    localparam logic [2:0] PTR_CFG = 3'h1;
    localparam logic [2:0] PTR_HYST = 3'h2;
    localparam logic [2:0] PTR_OS = 3'h3;
    localparam logic [2:0] PTR_ONESHOT = 3'h4;

    // Power-on values.
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [15:0] HYST_RESET = 16'h4b00;
    localparam logic [15:0] OS_RESET = 16'h5000;

    // Configuration field positions; bits 7 and 6 are reserved.
    localparam int CFG_SHUTDOWN_BIT = 0;
    localparam int CFG_INTMODE_BIT = 1;
    localparam int CFG_POL_BIT = 2;
    localparam int CFG_FQ_LSB = 3;
    localparam int CFG_ONESHOT_BIT = 5;
    localparam logic [7:0] CFG_WR_MASK = 8'h3f;

    // Fault queue depths for field codes 00, 01, 10 and 11.
    localparam logic [2:0] FQ_NEED_0 = 3'h1;
    localparam logic [2:0] FQ_NEED_1 = 3'h2;
    localparam logic [2:0] FQ_NEED_2 = 3'h4;
    localparam logic [2:0] FQ_NEED_3 = 3'h6;

    // Timing: update period and conversion time at the core clock rate.
    localparam int CLK_HZ = 10_000_000;
    localparam int UPDATE_MS = 80;
    localparam int CONV_US = 48_500;
    localparam int UPDATE_CYC = (CLK_HZ / 1000) * UPDATE_MS;
    localparam int CONV_CYC = (CLK_HZ / 1_000_000) * CONV_US;
    localparam int CNT_W = 20;

    // Conversion sequencer states.
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CONV = 2'b01,
        SEQ_WAIT = 2'b10
    } tsr_seq_t;

endpackage

// ==== tb/tsr_adc_model.sv ====
`timescale 1ns/1ns
module tsr_adc_model (
    // Clock.
    input wire logic core_clk,
    // Code to measure and converter state.
    input wire logic [11:0] temp_code,
    input wire logic conv_active,
    // Converter output.
    output logic [11:0] adc_code
);
    // Outside a conversion the code toggles, so a stale sample cannot pass.
    always_ff @(posedge core_clk) begin
        adc_code <= conv_active ? temp_code : ~adc_code;
    end
endmodule // tsr_adc_model

// ==== tb/tsr_core_asserts.sv ====
`timescale 1ns/1ns
module tsr_core_asserts #(
    parameter logic [19:0] UPDATE_CYC = 20'h00028,
    parameter logic [19:0] CONV_CYC = 20'h00014
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Register port.
    input wire logic bus_start,
    input wire logic bus_rnw,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rd_req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    // Converter and pin.
    input wire logic [11:0] adc_code,
    input wire logic conv_active,
    input wire logic overtemp_output,
    input wire logic overtemp_oe
);
    logic [19:0] conv_cnt_r;
    logic in_rd_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Conversion length and current transfer direction.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conv_cnt_r <= 20'h0;
            in_rd_r <= 1'b0;
        end else begin
            conv_cnt_r <= conv_active ? conv_cnt_r + 20'h1 : 20'h0;
            in_rd_r <= bus_start ? bus_rnw : in_rd_r;
        end
    end
    a_rd_answer: assert property (rd_valid |-> $past(rd_req))
        else $error("read data without request");
    a_rd_taken: assert property (rd_req && in_rd_r |=> rd_valid)
        else $error("read request not answered");
    a_rd_hold: assert property (!rd_req |=> $stable(rd_data))
        else $error("read byte changed without request");
    a_pin_open_drain: assert property (!overtemp_output)
        else $error("alert pin driven high");
    a_conv_bound: assert property (conv_active |-> conv_cnt_r < CONV_CYC)
        else $error("conversion too long");
    a_conv_restart: assert property (!$past(nrst) |-> ##1 conv_active)
        else $error("no conversion after reset");
    a_conv_gap: assert property ($fell(conv_active) |=> !conv_active)
        else $error("conversion restarted at once");
    a_oe_quiet: assert property ((!conv_active && !wr_valid && !rd_req) [*3]
        |=> $stable(overtemp_oe))
        else $error("alert changed without cause");
    c_read: cover property (rd_valid);
    c_conv_done: cover property ($fell(conv_active));
    c_alert: cover property ($rose(overtemp_oe));
endmodule // tsr_core_asserts

bind tsr_core tsr_core_asserts #(.UPDATE_CYC(UPDATE_CYC), .CONV_CYC(CONV_CYC)) chk_u (
    .core_clk(core_clk), .nrst(nrst), .bus_start(bus_start), .bus_rnw(bus_rnw),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .adc_code(adc_code), .conv_active(conv_active),
    .overtemp_output(overtemp_output), .overtemp_oe(overtemp_oe)
);

// ==== tb/temp_sensor_register_core_test.sv ====
`timescale 1ns/1ns
module temp_sensor_register_core_test;
    logic core_clk = 0;
    logic nrst = 0;
    logic bus_start = 0;
    logic bus_rnw = 0;
    logic wr_valid = 0;
    logic [7:0] wr_data = 8'h00;
    logic rd_req = 0;
    logic [11:0] code = 12'h190;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [11:0] adc_code;
    logic conv_active;
    logic oe;
    logic pin_drv;
    logic [15:0] v;
    int errors = 0;
    int total_checks = 0;
    int need[4] = '{1, 2, 4, 6};

    tsr_core #(.UPDATE_CYC(20'h00028), .CONV_CYC(20'h00014)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .bus_start(bus_start), .bus_rnw(bus_rnw),
        .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .adc_code(adc_code), .conv_active(conv_active),
        .overtemp_output(pin_drv), .overtemp_oe(oe)
    );
    tsr_adc_model adc_u (.core_clk(core_clk), .temp_code(code),
        .conv_active(conv_active), .adc_code(adc_code));

    // 10 MHz clock.
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task start(input logic rnw);
        @(posedge core_clk);
        #1 bus_start = 1;
        bus_rnw = rnw;
        @(posedge core_clk);
        #1 bus_start = 0;
    endtask

    task wbyte(input logic [7:0] b);
        @(posedge core_clk);
        #1 wr_valid = 1;
        wr_data = b;
        @(posedge core_clk);
        #1 wr_valid = 0;
        wr_data = ~b;
    endtask

    task wr_reg(input logic [7:0] p, input int n, input logic [15:0] d);
        start(0);
        wbyte(p);
        if (n == 2) wbyte(d[15:8]);
        if (n > 0) wbyte(d[7:0]);
    endtask

    // Reads n bytes at the current pointer, upper byte first.
    task rd_cur(input int n, output logic [15:0] r);
        start(1);
        r = 16'h0;
        repeat (n) begin
            @(posedge core_clk);
            #1 rd_req = 1;
            @(posedge core_clk);
            #1 rd_req = 0;
            chk("rd_valid", {15'h0, rd_valid}, 16'h1);
            r = {r[7:0], rd_data};
        end
    endtask

    task rd_reg(input logic [7:0] p, input int n, output logic [15:0] r);
        wr_reg(p, 0, 16'h0);
        rd_cur(n, r);
    endtask

    // Waits for the end of a conversion, bounded, then lets the pin settle.
    task wait_conv;
        int i;
        i = 0;
        while (conv_active !== 1'b1 && i < 200) begin
            @(posedge core_clk);
            i++;
        end
        while (conv_active !== 1'b0 && i < 200) begin
            @(posedge core_clk);
            i++;
        end
        if (i >= 200) begin
            chk("conv_timeout", 16'h1, 16'h0);
            tally_and_finish;
        end
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // Changes the measured code only between conversions, so no result mixes two codes.
    task set_code(input logic [11:0] c);
        int i;
        i = 0;
        while (conv_active !== 1'b0 && i < 200) begin
            @(posedge core_clk);
            i++;
        end
        if (i >= 200) begin
            chk("code_timeout", 16'h1, 16'h0);
            tally_and_finish;
        end
        #1 code = c;
    endtask

    task idle(input int n);
        logic s;
        s = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1 s = s | conv_active;
        end
        chk("idle", {15'h0, s}, 16'h0);
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge core_clk);
        #1 nrst = 1;
        rd_cur(2, v);
        chk("temp_reset", v, tsr_pkg::TEMP_RESET);
        rd_reg(8'h01, 1, v);
        chk("cfg_reset", v, {8'h0, tsr_pkg::CFG_RESET});
        rd_reg(8'h02, 2, v);
        chk("hyst_reset", v, tsr_pkg::HYST_RESET);
        rd_reg(8'h03, 2, v);
        chk("os_reset", v, tsr_pkg::OS_RESET);
        wait_conv;
        rd_reg(8'h00, 2, v);
        chk("temp_conv", v, 16'h1900);
        rd_reg(8'h00, 1, v);
        chk("temp_byte", v, 16'h0019);
        wr_reg(8'h00, 2, 16'hffff);
        rd_reg(8'h00, 2, v);
        chk("temp_ro", v, 16'h1900);
        code = 12'he70;
        wr_reg(8'h03, 2, 16'h1a5f);
        rd_reg(8'h03, 2, v);
        chk("os_nibble", v, 16'h1a50);
        wr_reg(8'h02, 2, 16'h1800);
        wr_reg(8'h03, 2, 16'h1900);
        for (int q = 0; q < 4; q++) begin
            wr_reg(8'h01, 1, {8'h0, 3'h0, 2'(q), 3'h0});
            set_code(12'h190);
            for (int i = 1; i <= need[q]; i++) begin
                wait_conv;
                chk("fault_q", {15'h0, oe}, {15'h0, i == need[q]});
            end
            set_code(12'he70);
            wait_conv;
            chk("cmp_clear", {15'h0, oe}, 16'h0);
        end
        wr_reg(8'h01, 1, 16'h0004);
        repeat (3) @(posedge core_clk);
        #1 chk("pol_high", {15'h0, oe}, 16'h1);
        chk("pin_data", {15'h0, pin_drv}, 16'h0);
        wr_reg(8'h01, 1, 16'h0002);
        set_code(12'h190);
        wait_conv;
        chk("int_trip", {15'h0, oe}, 16'h1);
        set_code(12'he70);
        wait_conv;
        chk("int_hold", {15'h0, oe}, 16'h1);
        rd_reg(8'h01, 1, v);
        repeat (3) @(posedge core_clk);
        #1 chk("int_clear", {15'h0, oe}, 16'h0);
        wr_reg(8'h01, 1, 16'h0001);
        repeat (2) @(posedge core_clk);
        idle(100);
        rd_reg(8'h00, 2, v);
        chk("sd_temp", v, 16'he700);
        code = 12'h100;
        wr_reg(8'h04, 1, 16'h005a);
        wait_conv;
        rd_reg(8'h00, 2, v);
        chk("sd_shot", v, 16'h1000);
        idle(60);
        wr_reg(8'h01, 1, 16'h0020);
        repeat (2) @(posedge core_clk);
        idle(60);
        code = 12'h200;
        wr_reg(8'h04, 1, 16'h00a5);
        wait_conv;
        rd_reg(8'h04, 1, v);
        chk("shot_data", v, 16'h0000);
        rd_reg(8'h00, 2, v);
        chk("shot_temp", v, 16'h2000);
        code = 12'h210;
        wr_reg(8'h01, 1, 16'h0000);
        wait_conv;
        rd_reg(8'h00, 2, v);
        chk("resume", v, 16'h2100);
        tally_and_finish;
    end
endmodule // temp_sensor_register_core_test
